//--- acc_top.sv
// The register offsets and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
module acc_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Raw conversions from the modulator and filter
  input  wire logic        raw_valid,
  input  wire logic [23:0] raw_data,
  // Converter controls
  output logic             conv_request,
  output logic [1:0]       cal_input_sel,
  output logic [3:0]       rate_select,
  output logic [1:0]       line_reject_select,
  output logic [2:0]       gain_select,
  output logic             cal_busy
);
  import acc_pkg::*;

  acc_mem_if mem_bus ();
  acc_result_mem u_mem (
    .mclk    (mclk),
    .reset_n (reset_n),
    .port_m  (mem_bus.mem)
  );
  acc_state_e         state;
  logic [1:0]         system_set_select;
  logic [3:0]         result_slot_select;
  logic [23:0]        self_zero;
  logic [23:0]        self_scale [8];
  logic [23:0]        system_zero_coeff_first;
  logic [23:0]        system_zero_coeff_second;
  logic [23:0]        system_scale_coeff_first;
  logic [23:0]        system_scale_coeff_second;
  logic [2:0]         cmd;
  logic [2:0]         cal_gain;
  logic               phase;
  logic [23:0]        pend_zero;
  logic signed [31:0] work;
  logic [33:0]        rem;
  logic [23:0]        quo;
  logic [4:0]         cnt;
  logic [31:0]        rd_mux;
  logic               wr_go;
  logic               cal_go;
  logic [2:0]         gidx;
  logic [23:0]        sel_zero;
  logic [23:0]        sel_scale;
  logic [23:0]        cal_zero;
  logic [33:0]        den;

  function automatic logic signed [31:0] ext24(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction
  // Raw code to half-LSB units so offsets keep their finer step
  function automatic logic signed [31:0] half(input logic [23:0] v);
    return {{7{v[23]}}, v, 1'b0};
  endfunction
  function automatic logic signed [31:0] q23_mul(input logic signed [31:0] a, input logic [23:0] g);
    logic signed [56:0] p;
    p = a * $signed({1'b0, g});
    return 32'(p >>> 23);
  endfunction
  function automatic logic [23:0] sat24(input logic signed [31:0] v);
    logic [23:0] r;
    r = v[23:0];
    if (v > ACC_POS_LIMIT) begin
      r = ACC_POS_LIMIT[23:0];
    end else if (v < ACC_NEG_LIMIT) begin
      r = ACC_NEG_LIMIT[23:0];
    end
    return r;
  endfunction
  function automatic logic addr_ok(input logic [7:0] a, input logic wr);
    logic ro;
    logic hit;
    ro  = (a == ACC_STATUS_OFS) || (a[7:5] == ACC_RESULT_BASE[7:5]);
    hit = ro || (a == ACC_CTRL_OFS) || (a == ACC_CAL_START_OFS) || (a == ACC_SELF_ZERO_OFS) ||
          (a[7:5] == ACC_SELF_SCALE_BASE[7:5]) || (a == ACC_SYS_ZERO_A_OFS) ||
          (a == ACC_SYS_SCALE_A_OFS) || (a == ACC_SYS_ZERO_B_OFS) || (a == ACC_SYS_SCALE_B_OFS);
    return hit && (a[1:0] == 2'h0) && !(wr && ro);
  endfunction
  function automatic logic cmd_valid(input logic [2:0] c);
    return (c == ACC_CMD_SELF) || (c == ACC_CMD_GAIN) || c[2];
  endfunction
  // APB: every access ends on its second access cycle; the decode is held stable by the master
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= !addr_ok(paddr, pwrite);
        prdata  <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end
  assign wr_go  = psel && penable && pready && pwrite && !pslverr;
  assign cal_go = wr_go && (paddr == ACC_CAL_START_OFS) && cmd_valid(pwdata[2:0]) && (state == ST_IDLE);
  assign mem_bus.rd_en   = psel && !penable && (paddr[7:5] == ACC_RESULT_BASE[7:5]);
  assign mem_bus.rd_addr = paddr[4:2];

  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      ACC_CTRL_OFS: begin
        rd_mux[ACC_RATE_LSB +: 4] = rate_select;
        rd_mux[ACC_LINE_LSB +: 2] = line_reject_select;
        rd_mux[ACC_GAIN_LSB +: 3] = gain_select;
        rd_mux[ACC_SET_LSB +: 2]  = system_set_select;
        rd_mux[ACC_SLOT_LSB +: 4] = result_slot_select;
      end
      ACC_STATUS_OFS: begin
        rd_mux[ACC_BUSY_LSB]       = cal_busy;
        rd_mux[ACC_PHASE_LSB]      = phase;
        rd_mux[ACC_INSEL_LSB +: 2] = cal_input_sel;
        rd_mux[ACC_CMD_LSB +: 3]   = cmd;
      end
      ACC_SELF_ZERO_OFS:   rd_mux[23:0] = self_zero;
      ACC_SYS_ZERO_A_OFS:  rd_mux[23:0] = system_zero_coeff_first;
      ACC_SYS_SCALE_A_OFS: rd_mux[23:0] = system_scale_coeff_first;
      ACC_SYS_ZERO_B_OFS:  rd_mux[23:0] = system_zero_coeff_second;
      ACC_SYS_SCALE_B_OFS: rd_mux[23:0] = system_scale_coeff_second;
      default: begin
        if (paddr[7:5] == ACC_SELF_SCALE_BASE[7:5]) begin
          rd_mux[23:0] = self_scale[paddr[4:2]];
        end else if (paddr[7:5] == ACC_RESULT_BASE[7:5]) begin
          rd_mux[23:0] = mem_bus.rd_data;
        end
      end
    endcase
  end

  // Control fields; rate and filter go straight to the converter, which paces every calibration
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rate_select        <= ACC_RATE_RST;
      line_reject_select <= ACC_LINE_RST;
      gain_select        <= ACC_GAIN_RST;
      system_set_select  <= ACC_SET_NONE;
      result_slot_select <= ACC_SLOT_RST;
    end else if (wr_go && (paddr == ACC_CTRL_OFS)) begin
      rate_select        <= pwdata[ACC_RATE_LSB +: 4];
      line_reject_select <= pwdata[ACC_LINE_LSB +: 2];
      gain_select        <= pwdata[ACC_GAIN_LSB +: 3];
      system_set_select  <= pwdata[ACC_SET_LSB +: 2];
      result_slot_select <= pwdata[ACC_SLOT_LSB +: 4];
    end
  end

  // Coefficient store; the calibration commit is written last so it wins over a host write
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      self_zero                 <= ACC_ZERO_COEFF;
      system_zero_coeff_first   <= ACC_ZERO_COEFF;
      system_zero_coeff_second  <= ACC_ZERO_COEFF;
      system_scale_coeff_first  <= ACC_UNITY_GAIN;
      system_scale_coeff_second <= ACC_UNITY_GAIN;
      for (int i = 0; i < 8; i++) begin
        self_scale[i] <= ACC_UNITY_GAIN;
      end
    end else begin
      if (wr_go) begin
        case (paddr)
          ACC_SELF_ZERO_OFS:   self_zero                 <= pwdata[23:0];
          ACC_SYS_ZERO_A_OFS:  system_zero_coeff_first   <= pwdata[23:0];
          ACC_SYS_SCALE_A_OFS: system_scale_coeff_first  <= pwdata[23:0];
          ACC_SYS_ZERO_B_OFS:  system_zero_coeff_second  <= pwdata[23:0];
          ACC_SYS_SCALE_B_OFS: system_scale_coeff_second <= pwdata[23:0];
          default: begin
            if (paddr[7:5] == ACC_SELF_SCALE_BASE[7:5]) begin
              self_scale[paddr[4:2]] <= pwdata[23:0];
            end
          end
        endcase
      end
      if (state == ST_COMMIT) begin
        case (cmd)
          ACC_CMD_SELF: begin
            self_zero     <= pend_zero;
            self_scale[0] <= quo;
          end
          ACC_CMD_GAIN:     self_scale[cal_gain]      <= quo;
          ACC_CMD_SZERO_A:  system_zero_coeff_first   <= sat24(work);
          ACC_CMD_SZERO_B:  system_zero_coeff_second  <= sat24(work);
          ACC_CMD_SSCALE_A: system_scale_coeff_first  <= quo;
          ACC_CMD_SSCALE_B: system_scale_coeff_second <= quo;
          default: ;
        endcase
      end
    end
  end
  // Coefficient selection for the datapath
  assign gidx = cal_busy ? cal_gain : gain_select;

  always_comb begin
    sel_zero  = ACC_ZERO_COEFF;
    sel_scale = ACC_UNITY_GAIN;
    case (system_set_select)
      ACC_SET_FIRST: begin
        sel_zero  = system_zero_coeff_first;
        sel_scale = system_scale_coeff_first;
      end
      ACC_SET_SECOND: begin
        sel_zero  = system_zero_coeff_second;
        sel_scale = system_scale_coeff_second;
      end
      default: ;
    endcase
  end
  assign cal_zero = cmd[1] ? system_zero_coeff_second : system_zero_coeff_first;
  assign den      = {2'h0, work};
  // Result write; slot codes above seven drop the result
  assign mem_bus.wr_en   = (state == ST_STORE) && !result_slot_select[3];
  assign mem_bus.wr_addr = result_slot_select[2:0];
  assign mem_bus.wr_data = sat24(work >>> 1);

  // Sequencer shared by normal correction and all calibrations
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state         <= ST_IDLE;
      cmd           <= ACC_CMD_SELF;
      cal_gain      <= ACC_GAIN_RST;
      phase         <= 1'b0;
      pend_zero     <= ACC_ZERO_COEFF;
      work          <= 32'sh00000000;
      rem           <= 34'h000000000;
      quo           <= ACC_ZERO_COEFF;
      cnt           <= 5'h00;
      conv_request  <= 1'b0;
      cal_input_sel <= ACC_IN_PINS;
      cal_busy      <= 1'b0;
    end else begin
      conv_request <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cal_go) begin
            cmd          <= pwdata[2:0];
            cal_gain     <= gain_select;
            phase        <= 1'b0;
            cal_busy     <= 1'b1;
            conv_request <= 1'b1;
            state        <= ST_WAIT;
            cal_input_sel <= pwdata[2] ? ACC_IN_PINS : (pwdata[0] ? ACC_IN_FULL : ACC_IN_ZERO);
          end else if (raw_valid) begin
            work  <= half(raw_data) - ext24(self_zero);
            state <= ST_SELFG;
          end
        end
        ST_WAIT: begin
          if (raw_valid) begin
            case (cmd)
              ACC_CMD_SELF: begin
                if (!phase) begin
                  pend_zero     <= sat24(half(raw_data));
                  phase         <= 1'b1;
                  conv_request  <= 1'b1;
                  cal_input_sel <= ACC_IN_FULL;
                end else begin
                  work  <= half(raw_data) - ext24(pend_zero);
                  state <= ST_DIV_INIT;
                end
              end
              ACC_CMD_GAIN: begin
                work  <= half(raw_data) - ext24(self_zero);
                state <= ST_DIV_INIT;
              end
              default: begin
                work  <= half(raw_data) - ext24(self_zero);
                state <= ST_SELFG;
              end
            endcase
          end
        end
        ST_SELFG: begin
          work <= q23_mul(work, self_scale[gidx]);
          if (cal_busy && !cmd[0]) begin
            state <= ST_COMMIT;
          end else begin
            state <= ST_SYS;
          end
        end
        ST_SYS: begin
          if (cal_busy) begin
            work  <= work - ext24(cal_zero);
            state <= ST_DIV_INIT;
          end else begin
            work  <= work - ext24(sel_zero);
            state <= ST_SCALE;
          end
        end
        ST_SCALE: begin
          work  <= q23_mul(work, sel_scale);
          state <= ST_STORE;
        end
        ST_STORE: state <= ST_IDLE;
        ST_DIV_INIT: begin
          // A zero or negative reading, or one needing a gain of two or more, saturates
          if ((work <= 32'sh00000000) || ((work <<< 1) <= ACC_FS_HALF)) begin
            quo   <= ACC_MAX_GAIN;
            state <= ST_COMMIT;
          end else begin
            rem   <= {2'h0, ACC_FS_HALF};
            quo   <= ACC_ZERO_COEFF;
            cnt   <= 5'h00;
            state <= ST_DIV;
          end
        end
        ST_DIV: begin
          // Restoring division; first quotient bit is the integer bit of the gain
          if (rem >= den) begin
            quo <= {quo[22:0], 1'b1};
            rem <= 34'((rem - den) << 1);
          end else begin
            quo <= {quo[22:0], 1'b0};
            rem <= 34'(rem << 1);
          end
          cnt <= cnt + 5'h01;
          if (cnt == ACC_DIV_STEPS - 5'h01) begin
            state <= ST_COMMIT;
          end
        end
        ST_COMMIT: begin
          cal_busy      <= 1'b0;
          cal_input_sel <= ACC_IN_PINS;
          state         <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- acc_pkg.sv
package acc_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] ACC_CTRL_OFS          = 8'h00;
  localparam logic [7:0] ACC_CAL_START_OFS     = 8'h04;
  localparam logic [7:0] ACC_STATUS_OFS        = 8'h08;
  localparam logic [7:0] ACC_SELF_ZERO_OFS     = 8'h10;
  localparam logic [7:0] ACC_SELF_SCALE_BASE   = 8'h20;
  localparam logic [7:0] ACC_SYS_ZERO_A_OFS    = 8'h40;
  localparam logic [7:0] ACC_SYS_SCALE_A_OFS   = 8'h44;
  localparam logic [7:0] ACC_SYS_ZERO_B_OFS    = 8'h48;
  localparam logic [7:0] ACC_SYS_SCALE_B_OFS   = 8'h4c;
  localparam logic [7:0] ACC_RESULT_BASE       = 8'h60;

  // Control register field positions
  localparam int ACC_RATE_LSB = 0;
  localparam int ACC_LINE_LSB = 4;
  localparam int ACC_GAIN_LSB = 8;
  localparam int ACC_SET_LSB  = 12;
  localparam int ACC_SLOT_LSB = 16;

  // Status register field positions
  localparam int ACC_BUSY_LSB  = 0;
  localparam int ACC_PHASE_LSB = 1;
  localparam int ACC_INSEL_LSB = 2;
  localparam int ACC_CMD_LSB   = 4;

  // Values after reset, and the saturated gain
  localparam logic [23:0] ACC_ZERO_COEFF = 24'h000000;
  localparam logic [23:0] ACC_UNITY_GAIN = 24'h800000;
  localparam logic [23:0] ACC_MAX_GAIN   = 24'hffffff;
  localparam logic [3:0]  ACC_RATE_RST   = 4'h0;
  localparam logic [1:0]  ACC_LINE_RST   = 2'h0;
  localparam logic [2:0]  ACC_GAIN_RST   = 3'h0;
  localparam logic [3:0]  ACC_SLOT_RST   = 4'h0;

  // Calibration commands, low three bits of the start register
  localparam logic [2:0] ACC_CMD_SELF    = 3'h0;
  localparam logic [2:0] ACC_CMD_GAIN    = 3'h1;
  localparam logic [2:0] ACC_CMD_SZERO_A = 3'h4;
  localparam logic [2:0] ACC_CMD_SSCALE_A = 3'h5;
  localparam logic [2:0] ACC_CMD_SZERO_B = 3'h6;
  localparam logic [2:0] ACC_CMD_SSCALE_B = 3'h7;

  // System set selection
  localparam logic [1:0] ACC_SET_NONE   = 2'h0;
  localparam logic [1:0] ACC_SET_FIRST  = 2'h1;
  localparam logic [1:0] ACC_SET_SECOND = 2'h2;

  // Converter input connection
  localparam logic [1:0] ACC_IN_PINS = 2'h0;
  localparam logic [1:0] ACC_IN_ZERO = 2'h1;
  localparam logic [1:0] ACC_IN_FULL = 2'h2;

  // Full-scale target in half-LSB units, and divider length in cycles
  localparam logic signed [31:0] ACC_FS_HALF   = 32'sh00fffffe;
  localparam logic signed [31:0] ACC_POS_LIMIT = 32'sh007fffff;
  localparam logic signed [31:0] ACC_NEG_LIMIT = 32'shff800000;
  localparam logic [4:0]         ACC_DIV_STEPS = 5'h18;

  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT, ST_SELFG, ST_SYS, ST_SCALE,
    ST_STORE, ST_DIV_INIT, ST_DIV, ST_COMMIT
  } acc_state_e;

endpackage

//--- acc_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface acc_mem_if;
  logic        wr_en;
  logic [2:0]  wr_addr;
  logic [23:0] wr_data;
  logic        rd_en;
  logic [2:0]  rd_addr;
  logic [23:0] rd_data;
  modport mem  (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
  modport user (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
endinterface
`default_nettype wire

//--- acc_result_mem.sv
`timescale 1ns/100ps
`default_nettype none
module acc_result_mem (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Access port
  acc_mem_if.mem   port_m
);
  logic [23:0] words [8];

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 8; i++) begin
        words[i] <= 24'h000000;
      end
    end else if (port_m.wr_en) begin
      words[port_m.wr_addr] <= port_m.wr_data;
    end
  end

  // Registered read keeps the bus mux off the array output
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      port_m.rd_data <= 24'h000000;
    end else if (port_m.rd_en) begin
      port_m.rd_data <= words[port_m.rd_addr];
    end
  end
endmodule
`default_nettype wire

//--- acc_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module acc_top_assertions
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Converter side
  input wire logic        raw_valid,
  input wire logic [23:0] raw_data,
  input wire logic        conv_request,
  input wire logic [1:0]  cal_input_sel,
  input wire logic [3:0]  rate_select,
  input wire logic [1:0]  line_reject_select,
  input wire logic [2:0]  gain_select,
  input wire logic        cal_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic start_wr;
  assign start_wr = psel && penable && pready && pwrite && paddr == ACC_CAL_START_OFS && !cal_busy;

  property p_ready_slot; (psel && !penable) ##1 (psel && penable) |=> pready; endproperty
  a_ready_slot: assert property (p_ready_slot) else $error("pready late");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_ready_access; pready |-> psel && penable; endproperty
  a_ready_access: assert property (p_ready_access) else $error("pready outside access");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
  // Input connection follows the command kind: self zero first, gain full, system pins
  property p_cal_accept;
    start_wr && pwdata[2:1] != 2'b01 |=> cal_busy && conv_request &&
      cal_input_sel == ($past(pwdata[2]) ? ACC_IN_PINS : ($past(pwdata[0]) ? ACC_IN_FULL : ACC_IN_ZERO));
  endproperty
  a_cal_accept: assert property (p_cal_accept) else $error("calibration start wrong");
  property p_bad_code; start_wr && pwdata[2:1] == 2'b01 |=> !cal_busy; endproperty
  a_bad_code: assert property (p_bad_code) else $error("reserved code started");
  property p_req_busy; conv_request |-> cal_busy; endproperty
  a_req_busy: assert property (p_req_busy) else $error("request while idle");
  property p_req_pulse; conv_request |=> !conv_request; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request held");
  property p_sel_busy; cal_input_sel != ACC_IN_PINS |-> cal_busy; endproperty
  a_sel_busy: assert property (p_sel_busy) else $error("internal input while idle");
endmodule
bind acc_top acc_top_assertions u_chk (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .raw_valid(raw_valid), .raw_data(raw_data), .conv_request(conv_request), .cal_input_sel(cal_input_sel),
  .rate_select(rate_select), .line_reject_select(line_reject_select), .gain_select(gain_select),
  .cal_busy(cal_busy));
`default_nettype wire

//--- acc_conv_model.sv
`timescale 1ns/100ps
`default_nettype none
module acc_conv_model
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset_n,
  // Requests and input choice
  input wire logic        conv_request,
  input wire logic        conv_now,
  input wire logic [1:0]  cal_input_sel,
  // Delay and input levels
  input wire logic [7:0]  lag,
  input wire logic [23:0] zero_v,
  input wire logic [23:0] full_v,
  input wire logic [23:0] pin_v,
  // Conversion out
  output logic            raw_valid,
  output logic [23:0]     raw_data
);
  logic        pend;
  logic [7:0]  cnt;
  logic [23:0] last;
  logic [23:0] val;
  // Internal zero and full scale chosen by the block, pins otherwise
  assign val = cal_input_sel == ACC_IN_ZERO ? zero_v : (cal_input_sel == ACC_IN_FULL ? full_v : pin_v);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pend      <= 1'b0;
      cnt       <= 8'h00;
      raw_valid <= 1'b0;
      raw_data  <= 24'h000000;
      last      <= 24'h000000;
    end else begin
      raw_valid <= 1'b0;
      // Data is not held after the pulse, so a late sample sees garbage
      raw_data  <= ~last;
      if (conv_request || conv_now) begin
        pend <= 1'b1;
        cnt  <= lag;
      end else if (pend) begin
        if (cnt == 8'h00) begin
          pend      <= 1'b0;
          raw_valid <= 1'b1;
          raw_data  <= val;
          last      <= val;
        end else begin
          cnt <= cnt - 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- adc_calibration_correction_test.sv
`timescale 1ns/100ps
`default_nettype none
module adc_calibration_correction_test;
  import acc_pkg::*;
  logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, raw_valid, conv_request, cal_busy, conv_now;
  logic [7:0]  paddr, lag;
  logic [31:0] pwdata, prdata;
  logic [23:0] raw_data, zero_v, full_v, pin_v;
  logic [1:0]  cal_input_sel, line_reject_select;
  logic [3:0]  rate_select;
  logic [2:0]  gain_select;
  int          bad_count, comparisons;

  acc_top dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .raw_valid(raw_valid),
    .raw_data(raw_data), .conv_request(conv_request), .cal_input_sel(cal_input_sel), .rate_select(rate_select),
    .line_reject_select(line_reject_select), .gain_select(gain_select), .cal_busy(cal_busy));
  acc_conv_model u_conv (.mclk(mclk), .reset_n(reset_n), .conv_request(conv_request), .conv_now(conv_now),
    .cal_input_sel(cal_input_sel), .lag(lag), .zero_v(zero_v), .full_v(full_v), .pin_v(pin_v),
    .raw_valid(raw_valid), .raw_data(raw_data));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Holds the request until pready is sampled high, then releases
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready", 1, 0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk($sformatf("reg %h", a), x, q);
  endtask

  task automatic idle_wait();
    int n;
    n = 0;
    while (cal_busy !== 1'b0 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 2000) chk("cal_busy", 0, 1);
  endtask

  task automatic cal(input logic [2:0] c);
    wr(ACC_CAL_START_OFS, {29'h0, c});
    @(posedge mclk);
    chk("cal_busy", 1, {31'h0, cal_busy});
    idle_wait();
  endtask

  task automatic conv(input logic [23:0] v);
    int n;
    pin_v <= v;
    conv_now <= 1'b1;
    @(posedge mclk);
    conv_now <= 1'b0;
    n = 0;
    while (raw_valid !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 100) chk("raw_valid", 1, 0);
    repeat (8) @(posedge mclk);
  endtask

  task automatic t_reset();
    logic [31:0] q;
    logic e;
    for (int g = 0; g < 8; g++) rd(ACC_SELF_SCALE_BASE + 8'(4 * g), {8'h0, ACC_UNITY_GAIN});
    rd(ACC_SELF_ZERO_OFS, 32'h0);
    rd(ACC_SYS_ZERO_A_OFS, 32'h0);
    rd(ACC_SYS_ZERO_B_OFS, 32'h0);
    rd(ACC_SYS_SCALE_A_OFS, {8'h0, ACC_UNITY_GAIN});
    rd(ACC_SYS_SCALE_B_OFS, {8'h0, ACC_UNITY_GAIN});
    apb(1'b0, 8'h5c, 32'h0, q, e);
    chk("unmapped pslverr", 1, {31'h0, e});
    $display("reset test done");
  endtask

  task automatic t_correct();
    wr(ACC_SELF_ZERO_OFS, 32'h11);
    wr(ACC_SYS_ZERO_A_OFS, 32'h20);
    wr(ACC_SYS_SCALE_A_OFS, 32'hc00000);
    wr(ACC_CTRL_OFS, 32'h0003_1025);
    @(posedge mclk);
    chk("rate", 5, {28'h0, rate_select});
    chk("line", 2, {30'h0, line_reject_select});
    conv(24'd1000);
    rd(ACC_RESULT_BASE + 8'h0c, 32'h5b7);
    wr(ACC_CTRL_OFS, 32'h0007_0025);
    conv(24'd1000);
    rd(ACC_RESULT_BASE + 8'h1c, 32'h3df);
    $display("correction test done");
  endtask

  task automatic t_self();
    lag <= 8'd20;
    zero_v <= 24'h000004;
    full_v <= 24'h400004;
    wr(ACC_CAL_START_OFS, 32'h8);
    rd(ACC_SELF_ZERO_OFS, 32'h11);
    idle_wait();
    rd(ACC_SELF_ZERO_OFS, 32'h8);
    rd(ACC_SELF_SCALE_BASE, 32'hfffffe);
    $display("self calibration test done");
  endtask

  task automatic t_gain();
    lag <= 8'd0;
    full_v <= 24'h200000;
    wr(ACC_SELF_ZERO_OFS, 32'h0);
    wr(ACC_CTRL_OFS, 32'h0007_0525);
    @(posedge mclk);
    chk("gain", 5, {29'h0, gain_select});
    cal(ACC_CMD_GAIN);
    rd(ACC_SELF_SCALE_BASE + 8'h14, 32'hffffff);
    rd(ACC_SELF_SCALE_BASE, 32'hfffffe);
    wr(ACC_CAL_START_OFS, 32'h2);
    @(posedge mclk);
    chk("reserved code busy", 0, {31'h0, cal_busy});
    $display("gain calibration test done");
  endtask

  task automatic t_sys();
    logic [7:0] a;
    wr(ACC_SELF_SCALE_BASE, 32'h800000);
    wr(ACC_CTRL_OFS, 32'h0007_0025);
    for (int s = 0; s < 2; s++) begin
      a = s ? ACC_SYS_ZERO_B_OFS : ACC_SYS_ZERO_A_OFS;
      wr(a, 32'h123);
      pin_v <= s ? 24'hfffffd : 24'h000000;
      cal(s ? ACC_CMD_SZERO_B : ACC_CMD_SZERO_A);
      rd(a, s ? 32'hfffffa : 32'h0);
    end
    for (int s = 0; s < 2; s++) begin
      pin_v <= s ? 24'hf00000 : 24'h200000;
      cal(s ? ACC_CMD_SSCALE_B : ACC_CMD_SSCALE_A);
      rd(s ? ACC_SYS_SCALE_B_OFS : ACC_SYS_SCALE_A_OFS, 32'hffffff);
    end
    wr(ACC_CTRL_OFS, 32'h0007_2025);
    conv(24'd1000);
    rd(ACC_RESULT_BASE + 8'h1c, 32'h7d5);
    $display("system calibration test done");
  endtask

  task automatic conclude();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    conclude();
  end

  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    conv_now = 1'b0;
    lag = 8'd0;
    zero_v = 24'h0;
    full_v = 24'h0;
    pin_v = 24'h0;
    bad_count = 0;
    comparisons = 0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_correct();
    t_self();
    t_gain();
    t_sys();
    conclude();
  end
endmodule
`default_nettype wire
